// ==== core/clock_control_consts.vh ====
// Constants of the clock source and start-up control block
`ifndef CLOCK_CONTROL_CONSTS_VH
`define CLOCK_CONTROL_CONSTS_VH
// ==========================================================
// Register byte offsets
`define REG_CONTROL          8'h00
`define REG_STATUS           8'h04
`define REG_FUSES            8'h08
// ==========================================================
// Control register fields
`define CTRL_MODE_LSB        0
`define CTRL_MODE_MSB        2
`define CTRL_SLEEP_BIT       3
`define CTRL_RESET           3'h0
// ==========================================================
// Status register fields
`define STAT_STATE_LSB       0
`define STAT_CLASS_LSB       4
`define STAT_RANGE_LSB       8
`define STAT_SWING_BIT       10
`define STAT_RESET_BIT       11
// ==========================================================
// Unconfigured fuse values (one means unprogrammed)
`define FUSE_SRC_RESET       4'h1
`define FUSE_SUT_RESET       2'h2
`define FUSE_OPT_RESET       1'h1
// ==========================================================
// Source classes
`define CLASS_CRYSTAL        3'h0
`define CLASS_LOW_FREQ       3'h1
`define CLASS_EXT_RC         3'h2
`define CLASS_INT_RC         3'h3
`define CLASS_EXT_CLOCK      3'h4
// ==========================================================
// Reset delay selections
`define RDLY_NONE            2'h0
`define RDLY_SHORT           2'h1
`define RDLY_LONG            2'h2
// ==========================================================
// Sleep modes
`define MODE_IDLE            3'h0
`define MODE_ADC_QUIET       3'h1
`define MODE_POWER_DOWN      3'h2
`define MODE_POWER_SAVE      3'h3
`define MODE_STANDBY         3'h6
`define MODE_EXT_STANDBY     3'h7
// ==========================================================
// Timing counts, in source or watchdog oscillator cycles
`define CNT_258              17'h00102
`define CNT_1K               17'h00400
`define CNT_16K              17'h04000
`define CNT_32K              17'h08000
`define CNT_18               17'h00012
`define CNT_6                17'h00006
`define CNT_WDT_SHORT        17'h01000
`define CNT_WDT_LONG         17'h10000
`endif

// ==== core/clock_source_startup_control.v ====
// Clock source decode, start-up timing and domain clock gating
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// How it works
// R1: Fuse codes map to crystal, low-frequency, external RC, internal RC, external clock.
// R2: A fuse bit of one is unprogrammed, zero is programmed.
// R3: Wake from power-down or power-save counts source cycles before execution resumes.
// R4: Start from reset adds 4,096 or 65,536 watchdog cycles as selected.
// R5: Unconfigured fuses are source 0001 and start-up 10.
// R6: Crystal range comes from upper three select bits, or wide with option fuse.
// R7: Programmed option fuse gives full swing; unprogrammed gives low-power swing.
// R8: Crystal start-up uses lowest select bit plus two start-up bits.
// R9: Low bit zero, codes 00/01: 258 cycles, delay short or long.
// R10: Codes 0/10, 0/11, 1/00: 1K cycles, delay none, short, long.
// R11: Low bit one, codes 01/10/11: 16K cycles, delay none, short, long.
// R12: Sleep modes stop clocks to unused domains.
// R13: Stopped core clock freezes register file, status and stack memory.
// R14: Program memory clock runs whenever the core clock runs.
// R15: Peripheral clock feeds timers; async interrupt detection works with it stopped.
// R16: Two-wire address recognition works asynchronously with peripheral clock stopped.
// R17: Async timer domain keeps running in sleep from its 32kHz crystal, except in power-down and standby.
// R18: Converter domain runs while core and peripheral clocks are stopped.
// R19: All domain clocks off and reset held until both start-up counts finish.
`include "clock_control_consts.vh"

module clock_source_startup_control #(
  parameter CNT_16K_P       = `CNT_16K,
  parameter CNT_32K_P       = `CNT_32K,
  parameter CNT_WDT_SHORT_P = `CNT_WDT_SHORT,
  parameter CNT_WDT_LONG_P  = `CNT_WDT_LONG,
  parameter CNT_EXT_CLK_P   = `CNT_6
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [3:0]  clock_source_select_fuses,
  input  wire [1:0]  startup_time_fuses,
  input  wire        oscillator_option_fuse,
  input  wire        source_tick,
  input  wire        watchdog_tick,
  input  wire        wake_event,
  output reg         core_clock_en,
  output reg         program_memory_clock_en,
  output reg         peripheral_clock_en,
  output reg         async_timer_clock_en,
  output reg         converter_clock_en,
  output reg         async_detect_en,
  output reg         internal_reset_n,
  output reg  [2:0]  source_class,
  output reg  [1:0]  crystal_range,
  output reg         amp_full_swing
);

  // ========================================================
  // States
  localparam ST_LOAD  = 3'h0;
  localparam ST_SRC   = 3'h1;
  localparam ST_WDT   = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_SLEEP = 3'h4;
  localparam ST_WAKE  = 3'h5;

  reg  [3:0]  src_fuse;
  reg  [1:0]  sut_fuse;
  reg         opt_fuse;
  reg  [2:0]  state;
  reg  [16:0] count;
  reg  [2:0]  sleep_mode;
  reg  [16:0] src_target;
  reg  [1:0]  rdly_sel;
  reg  [16:0] wdt_target;
  reg  [2:0]  next_class;
  reg  [1:0]  next_range;
  reg  [2:0]  next_mode;
  reg  [2:0]  next_state;
  reg  [16:0] next_count;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  wire        bus_take;
  wire [16:0] count_inc;
  wire        sleep_req;
  wire        deep_sleep;

  // ========================================================
  // Fuse capture
  // Fuses are straps: caught by the clock after reset release,
  // so the asynchronous reset only loads the shipped values.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_fuse <= `FUSE_SRC_RESET; // see R5
      sut_fuse <= `FUSE_SUT_RESET; // see R5
      opt_fuse <= `FUSE_OPT_RESET;
    end else if (state == ST_LOAD) begin
      src_fuse <= clock_source_select_fuses;
      sut_fuse <= startup_time_fuses;
      opt_fuse <= oscillator_option_fuse;
    end
  end

  // ========================================================
  // Source class and crystal range decode
  always @* begin
    next_class = `CLASS_EXT_CLOCK; // see R1
    if (src_fuse >= 4'ha)
      next_class = `CLASS_CRYSTAL; // see R1
    else if (src_fuse == 4'h9)
      next_class = `CLASS_LOW_FREQ; // see R1
    else if (src_fuse >= 4'h5)
      next_class = `CLASS_EXT_RC; // see R1
    else if (src_fuse >= 4'h1)
      next_class = `CLASS_INT_RC; // see R1
    // Zero on the option fuse means programmed: wide range
    if (opt_fuse == 1'b0)
      next_range = 2'h3; // see R2, R6
    else if (src_fuse[3:1] == 3'h7)
      next_range = 2'h2; // see R6
    else if (src_fuse[3:1] == 3'h6)
      next_range = 2'h1; // see R6
    else
      next_range = 2'h0; // see R6
  end

  // ========================================================
  // Start-up table: source cycles and reset delay
  // Reserved start-up codes fall back to the longest setting.
  always @* begin
    src_target = `CNT_6;
    rdly_sel   = `RDLY_LONG;
    case (next_class)
      `CLASS_CRYSTAL: begin
        case ({src_fuse[0], sut_fuse}) // see R8
          3'h0: begin
            src_target = `CNT_258; // see R9
            rdly_sel   = `RDLY_SHORT;
          end
          3'h1: begin
            src_target = `CNT_258; // see R9
            rdly_sel   = `RDLY_LONG;
          end
          3'h2: begin
            src_target = `CNT_1K; // see R10
            rdly_sel   = `RDLY_NONE;
          end
          3'h3: begin
            src_target = `CNT_1K; // see R10
            rdly_sel   = `RDLY_SHORT;
          end
          3'h4: begin
            src_target = `CNT_1K; // see R10
            rdly_sel   = `RDLY_LONG;
          end
          3'h5: begin
            src_target = CNT_16K_P[16:0]; // see R11
            rdly_sel   = `RDLY_NONE;
          end
          3'h6: begin
            src_target = CNT_16K_P[16:0]; // see R11
            rdly_sel   = `RDLY_SHORT;
          end
          default: begin
            src_target = CNT_16K_P[16:0]; // see R11
            rdly_sel   = `RDLY_LONG;
          end
        endcase
      end
      `CLASS_LOW_FREQ: begin
        src_target = (sut_fuse[1]) ? CNT_32K_P[16:0] : `CNT_1K;
        rdly_sel   = (sut_fuse == 2'h0) ? `RDLY_SHORT : `RDLY_LONG;
      end
      `CLASS_EXT_RC: begin
        src_target = (sut_fuse == 2'h3) ? `CNT_6 : `CNT_18;
        case (sut_fuse)
          2'h0:    rdly_sel = `RDLY_NONE;
          2'h2:    rdly_sel = `RDLY_LONG;
          default: rdly_sel = `RDLY_SHORT;
        endcase
      end
      `CLASS_INT_RC: begin
        src_target = `CNT_6;
        case (sut_fuse)
          2'h0:    rdly_sel = `RDLY_NONE;
          2'h1:    rdly_sel = `RDLY_SHORT;
          default: rdly_sel = `RDLY_LONG;
        endcase
      end
      default: begin
        src_target = CNT_EXT_CLK_P[16:0];
        case (sut_fuse)
          2'h0:    rdly_sel = `RDLY_NONE;
          2'h1:    rdly_sel = `RDLY_SHORT;
          default: rdly_sel = `RDLY_LONG;
        endcase
      end
    endcase
    wdt_target = (rdly_sel == `RDLY_LONG) ? CNT_WDT_LONG_P[16:0] :
                 CNT_WDT_SHORT_P[16:0]; // see R4
  end

  // ========================================================
  // Start-up and sleep sequencer
  assign count_inc  = count + 17'h00001;
  assign sleep_req  = wr_pend && (wr_addr == `REG_CONTROL) && hwdata[`CTRL_SLEEP_BIT];
  assign deep_sleep = (sleep_mode == `MODE_POWER_DOWN) ||
                      (sleep_mode == `MODE_POWER_SAVE);

  // Mode as it stands after this edge: a sleep entry with a fresh mode
  // gates the domains at once instead of one cycle late on the old mode.
  // The field only changes while awake, so it is stable through sleep.
  always @* begin
    next_mode = sleep_mode;
    if (wr_pend && (wr_addr == `REG_CONTROL) && (state == ST_RUN))
      next_mode = hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]; // see R12
  end

  // Next state: count ticks of the selected source, then watchdog ticks
  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_LOAD: begin
        next_state = ST_SRC;
        next_count = 17'h00000;
      end
      ST_SRC: begin
        if (source_tick) begin
          next_count = count_inc;
          if (count_inc == src_target) begin
            next_count = 17'h00000;
            next_state = (rdly_sel == `RDLY_NONE) ? ST_RUN : ST_WDT; // see R19
          end
        end
      end
      ST_WDT: begin
        if (watchdog_tick) begin
          next_count = count_inc; // see R4
          if (count_inc == wdt_target)
            next_state = ST_RUN; // see R4, R19
        end
      end
      ST_RUN: begin
        // A wake in the same cycle cancels the sleep entry
        if (sleep_req && !wake_event)
          next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        // Wake sources are detected outside the stopped domains
        if (wake_event) begin // see R15, R16
          next_count = 17'h00000;
          next_state = deep_sleep ? ST_WAKE : ST_RUN; // see R3
        end
      end
      ST_WAKE: begin
        if (source_tick) begin
          next_count = count_inc; // see R3
          if (count_inc == src_target)
            next_state = ST_RUN; // see R3
        end
      end
      default: begin
        next_state = ST_LOAD;
        next_count = 17'h00000;
      end
    endcase
  end

  // State and cycle counter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_LOAD;
      count <= 17'h00000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ========================================================
  // Domain clock enables, registered per state and sleep mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_clock_en           <= 1'b0;
      program_memory_clock_en <= 1'b0;
      peripheral_clock_en     <= 1'b0;
      async_timer_clock_en    <= 1'b0;
      converter_clock_en      <= 1'b0;
      async_detect_en         <= 1'b0;
      internal_reset_n        <= 1'b0;
    end else begin
      // Core stopped means register file and stack memory freeze
      core_clock_en           <= (next_state == ST_RUN); // see R13, R19
      program_memory_clock_en <= (next_state == ST_RUN); // see R14
      if (next_state == ST_RUN) begin
        peripheral_clock_en  <= 1'b1; // see R15
        async_timer_clock_en <= 1'b1;
        converter_clock_en   <= 1'b1;
        async_detect_en      <= 1'b0;
      end else if (next_state == ST_SLEEP) begin
        peripheral_clock_en  <= (next_mode == `MODE_IDLE); // see R12
        async_timer_clock_en <= (next_mode != `MODE_POWER_DOWN) &&
                                (next_mode != `MODE_STANDBY); // see R17
        converter_clock_en   <= (next_mode == `MODE_IDLE) ||
                                (next_mode == `MODE_ADC_QUIET); // see R18
        async_detect_en      <= (next_mode != `MODE_IDLE); // see R15, R16
      end else if (next_state == ST_WAKE) begin
        peripheral_clock_en  <= 1'b0;
        async_timer_clock_en <= (sleep_mode == `MODE_POWER_SAVE); // see R17
        converter_clock_en   <= 1'b0;
        async_detect_en      <= 1'b1;
      end else begin
        peripheral_clock_en  <= 1'b0; // see R19
        async_timer_clock_en <= 1'b0;
        converter_clock_en   <= 1'b0;
        async_detect_en      <= 1'b0;
      end
      // Reset stays asserted until the first entry to run
      if (next_state == ST_RUN)
        internal_reset_n <= 1'b1; // see R19
    end
  end

  // ========================================================
  // Decoded configuration outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_class   <= `CLASS_INT_RC;
      crystal_range  <= 2'h0;
      amp_full_swing <= 1'b0;
    end else begin
      source_class   <= next_class;
      crystal_range  <= next_range;
      amp_full_swing <= ~opt_fuse; // see R2, R7
    end
  end

  // ========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign bus_take = hsel && hready && htrans[1];

  // Address phase capture, mode register and read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      sleep_mode <= `CTRL_RESET;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend <= bus_take && hwrite;
      wr_addr <= haddr[7:0];
      // Mode register follows the decoded write
      sleep_mode <= next_mode; // see R12
      if (bus_take && !hwrite) begin
        case (haddr[7:0])
          `REG_CONTROL: hrdata <= {29'h00000000, sleep_mode};
          `REG_STATUS:  hrdata <= {20'h00000, internal_reset_n, amp_full_swing,
                                   crystal_range, 1'b0, source_class, 1'b0, state};
          `REG_FUSES:   hrdata <= {25'h0000000, opt_fuse, sut_fuse, src_fuse};
          default:      hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // clock_source_startup_control

// ==== core/clock_control_placeholder_note.v ====
// No logic here: the whole block lives in the principal design file

// ==== test/osc_source_model.sv ====
// Oscillator partner model: source and watchdog cycle pulses
`timescale 1ns/1ps
module osc_source_model (
  input  wire       hclk,
  input  wire [3:0] gap,
  output reg        source_tick,
  output reg        watchdog_tick
);
  reg [3:0] cnt = 4'h0;
  // =========================================================
  // Free-running oscillators, one pulse every gap cycles
  initial begin
    source_tick = 1'b0;
    watchdog_tick = 1'b0;
  end
  // A gap of one ticks every cycle; larger gaps model a slow source
  always @(posedge hclk) begin
    cnt <= (cnt + 4'h1 >= gap) ? 4'h0 : cnt + 4'h1;
    source_tick <= (cnt + 4'h1 >= gap);
    watchdog_tick <= (cnt + 4'h1 >= gap);
  end
endmodule // osc_source_model

// ==== test/clock_source_startup_control_props.sv ====
// Checker of the clock source and start-up control ports
`timescale 1ns/1ps
module clock_source_startup_control_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire [3:0]  clock_source_select_fuses,
  input wire [1:0]  startup_time_fuses,
  input wire        oscillator_option_fuse,
  input wire        core_clock_en,
  input wire        program_memory_clock_en,
  input wire        peripheral_clock_en,
  input wire        async_timer_clock_en,
  input wire        converter_clock_en,
  input wire        internal_reset_n,
  input wire [2:0]  source_class,
  input wire [1:0]  crystal_range,
  input wire        amp_full_swing
);
  wire [3:0] s = clock_source_select_fuses;
  wire [2:0] rdiff = s[3:1] - 3'h5;
  // =========================================================
  // Expected decode, independent of the design body
  wire [2:0] exp_class = (s == 4'h0) ? 3'h4 : (s <= 4'h4) ? 3'h3 :
                         (s <= 4'h8) ? 3'h2 : (s == 4'h9) ? 3'h1 : 3'h0;
  wire [1:0] exp_range = oscillator_option_fuse ? rdiff[1:0] : 2'h3;
  wire [4:0] ens = {core_clock_en, program_memory_clock_en, peripheral_clock_en,
                    async_timer_clock_en, converter_clock_en};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read of the fuse word, then its data phase
  sequence fuse_read;
    hsel && hready && htrans[1] && !hwrite && haddr == 32'h8;
  endsequence
  a_class_decode: assert property (internal_reset_n |-> source_class == exp_class)
    else $error("source class mismatch");
  a_fuse_readback: assert property (fuse_read |=> hrdata == {25'h0,
      oscillator_option_fuse, startup_time_fuses, s}) else $error("fuse word mismatch");
  a_crystal_range: assert property (internal_reset_n && source_class == 3'h0
      |-> crystal_range == exp_range) else $error("crystal range mismatch");
  a_amp_swing: assert property (internal_reset_n |-> amp_full_swing != oscillator_option_fuse)
    else $error("amplifier swing mismatch");
  a_flash_follows: assert property (program_memory_clock_en == core_clock_en)
    else $error("program memory clock differs from core clock");
  a_gated_reset: assert property (!internal_reset_n |-> ens == 5'h00)
    else $error("domain clock runs during start-up");
  a_min_startup: assert property ($rose(internal_reset_n) |-> $past(hresetn, 6))
    else $error("internal reset released too early");
  a_async_timer: assert property (peripheral_clock_en |-> async_timer_clock_en)
    else $error("async timer clock stopped while peripherals run");
  a_converter_dom: assert property (peripheral_clock_en |-> converter_clock_en)
    else $error("converter clock stopped while peripherals run");
endmodule // clock_source_startup_control_props

// ==== test/testbench.sv ====
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module testbench;
  localparam int WS = 8, WL = 16, C16 = 20, C32 = 40;
  reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  reg  [1:0]  htrans = 2'h0, startup_time_fuses = 2'h2;
  reg  [2:0]  hsize = 3'h2;
  reg  [3:0]  clock_source_select_fuses = 4'h1, gap = 4'h1;
  reg         oscillator_option_fuse = 1'b1, wake_event = 1'b0;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, source_tick, watchdog_tick, async_detect_en;
  wire        core_clock_en, program_memory_clock_en, peripheral_clock_en;
  wire        async_timer_clock_en, converter_clock_en, internal_reset_n, amp_full_swing;
  wire [2:0]  source_class;
  wire [1:0]  crystal_range;
  wire [4:0]  ens = {core_clock_en, program_memory_clock_en, peripheral_clock_en,
                     async_timer_clock_en, converter_clock_en};
  integer     errors = 0, checks_done = 0, seed = 10, n;
  int         mq[$] = '{0, 1, 2, 3, 6, 7};
  // =========================================================
  // Clock, partner and design
  always #25 hclk = ~hclk;
  osc_source_model osc (.hclk, .gap, .source_tick, .watchdog_tick);
  clock_source_startup_control #(.CNT_16K_P(C16), .CNT_32K_P(C32), .CNT_WDT_SHORT_P(WS),
      .CNT_WDT_LONG_P(WL), .CNT_EXT_CLK_P(6)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .clock_source_select_fuses, .startup_time_fuses, .oscillator_option_fuse, .source_tick,
      .watchdog_tick, .wake_event, .core_clock_en, .program_memory_clock_en,
      .peripheral_clock_en, .async_timer_clock_en, .converter_clock_en, .async_detect_en,
      .internal_reset_n, .source_class, .crystal_range, .amp_full_swing);
  // =========================================================
  // Reference model of the start-up tables
  function automatic int exp_src(input int s, input int u);
    if (s >= 10) return (s % 2 == 0) ? (u < 2 ? 258 : 1024) : (u == 0 ? 1024 : C16);
    if (s == 9) return u < 2 ? 1024 : C32;
    if (s >= 5) return u == 3 ? 6 : 18;
    return 6;
  endfunction
  // Reserved codes fall back to the long delay
  function automatic int exp_wdt(input int s, input int u);
    int k;
    if (s >= 10) k = (s % 2 == 0) ? (u < 2 ? u + 1 : u - 2) : (u == 0 ? 2 : u - 1);
    else if (s == 9) k = (u == 0) ? 1 : 2;
    else if (s >= 5) k = (u == 3) ? 1 : u;
    else k = (u == 3) ? 2 : u;
    return k == 0 ? 0 : (k == 1 ? WS : WL);
  endfunction
  function automatic [2:0] exp_class(input [3:0] s);
    return s == 0 ? 3'h4 : s <= 4 ? 3'h3 : s <= 8 ? 3'h2 : s == 9 ? 3'h1 : 3'h0;
  endfunction
  function automatic [4:0] sleep_en(input int m);
    return m == 0 ? 5'h07 : m == 1 ? 5'h03 : (m == 3 || m == 7) ? 5'h02 : 5'h00;
  endfunction
  // =========================================================
  // Compare, bus and verdict tasks
  task automatic check(input string nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic ahb(input [31:0] a, input w, input [31:0] d, output [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset with given fuses, then time the release of internal reset
  task automatic start(input [3:0] s, input [1:0] u, input o);
    hresetn <= 1'b0;
    clock_source_select_fuses <= s;
    startup_time_fuses <= u;
    oscillator_option_fuse <= o;
    repeat (2) @(posedge hclk);
    #1;
    check("reset_class", 3'h3, source_class);
    check("reset_gated", 6'h00, {ens, internal_reset_n});
    @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (internal_reset_n !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      #1;
      n = n + 1;
    end
    check("start_cycles", 1 + exp_src(s, u) + exp_wdt(s, u), n);
    check("class", exp_class(s), source_class);
    if (exp_class(s) == 3'h0) check("range", o ? s[3:1] - 3'h5 : 3'h3, crystal_range);
    check("swing", !o, amp_full_swing);
    check("run_enables", 5'h1f, ens);
    ahb(32'h4, 1'b0, 32'h0, rd);
    check("status", {20'h0, 1'b1, ~o, 3'h0, exp_class(s), 4'h3}, rd & 32'hfffffcff);
    ahb(32'h8, 1'b0, 32'h0, rd);
    check("fuses", {25'h0, o, u, s}, rd);
    check("bus_okay", 2'h2, {hreadyout, hresp});
  endtask
  // =========================================================
  // Main sequence: every fuse code, then every sleep mode
  initial begin
    for (int k = 0; k < 64; k++) start(k[5:2], k[1:0], 1'($random(seed)));
    start(4'hf, 2'h3, 1'b0);
    gap <= 4'h2;
    ahb(32'hc, 1'b1, 32'hffffffff, rd);
    ahb(32'hc, 1'b0, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    foreach (mq[i]) begin
      ahb(32'h0, 1'b1, mq[i], rd);
      ahb(32'h0, 1'b1, mq[i] | 8, rd);
      repeat (2) @(posedge hclk);
      #1;
      check("sleep_enables", sleep_en(mq[i]), ens);
      check("async_detect", mq[i] != 0, async_detect_en);
      @(posedge hclk);
      wake_event <= 1'b1;
      @(posedge hclk);
      wake_event <= 1'b0;
      n = 0;
      while (core_clock_en !== 1'b1 && n < 500) begin
        @(posedge hclk);
        #1;
        n = n + 1;
      end
      check("wake_wait", mq[i] == 2 || mq[i] == 3, n >= C16);
      ahb(32'h0, 1'b0, 32'h0, rd);
      check("control", mq[i], rd);
    end
    complete_run;
  end
  // Watchdog: the whole run needs well under this span
  initial begin
    repeat (100000) @(posedge hclk);
    errors = errors + 1;
    complete_run;
  end
endmodule // testbench
bind clock_source_startup_control clock_source_startup_control_props u_props (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .clock_source_select_fuses,
  .startup_time_fuses, .oscillator_option_fuse, .core_clock_en, .program_memory_clock_en,
  .peripheral_clock_en, .async_timer_clock_en, .converter_clock_en, .internal_reset_n,
  .source_class, .crystal_range, .amp_full_swing);
